// ==== verif/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in, rst_in, reg_write_in, reg_read_in, hsync_in, vsync_in, burst_line_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, burst_level_in, burst_threshold_value_in;
    logic [9:0] video_bus_a_in, video_bus_b_in, input_proc_out_a_out, input_proc_out_b_out;
    logic [9:0] primary_out, secondary_out, chroma_out;
    logic [1:0] lock_mode_out;
    logic proc_valid_out, decoder_valid_out, h_reset_out, v_reset_out, input_device_protocol_out;
    logic burst_loop_lock_mode_out, clock_type_select_out, demodulator_bypass_out;
    logic chroma_interpolation_enable_out, colour_kill_out;
    logic [9:0] hcnt = 10'h000, vcnt = 10'h000, pcnt = 10'h000, h0, v0;
    int error_cnt = 0, comparisons = 0;
    video_input_and_burst_loop_control DUT (.*);
    video_src_model src (.core_clk_in(core_clk_in), .bus_a_out(video_bus_a_in),
        .bus_b_out(video_bus_b_in), .hsync_out(hsync_in), .vsync_out(vsync_in),
        .burst_level_out(burst_level_in), .burst_line_out(burst_line_in));
    // Pixel clock; a line locked source would run it at twice the pixel rate.
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    // Pulse totals, so scenarios compare counts rather than chase single cycles.
    always @(posedge core_clk_in)
    begin
        if (!rst_in)
        begin
            hcnt <= hcnt + {9'h0, h_reset_out};
            vcnt <= vcnt + {9'h0, v_reset_out};
            pcnt <= pcnt + {9'h0, proc_valid_out};
        end
    end
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Register write; the strobe is held over exactly one taking edge.
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= {1'b0, d[6:0]};
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
    endtask
    // Register read; data is looked at once the registered answer has landed.
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= ad;
        reg_read_in <= 1'b1;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        @(posedge core_clk_in);
        #1 chk("rdata", {2'h0, reg_rdata_out}, {2'h0, exp});
    endtask
    // Offer one sample pair and stop just after the block has taken it.
    task automatic pix(input logic [9:0] a, input logic [9:0] b);
        src.send(a, b);
        @(posedge core_clk_in);
        #1;
    endtask
    // Bounded wait for the kill level; a hang ends the run.
    task automatic wait_kill(input logic lv);
        for (int n = 0; n < 20 && colour_kill_out !== lv; n++)
            @(posedge core_clk_in);
        #1 chk("kill", {9'h0, colour_kill_out}, {9'h0, lv});
        if (colour_kill_out !== lv)
            report_and_stop();
    endtask
    task automatic t_modes();
        logic [7:0] v;
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            v = {2'b01, i[1:0], i[0], 1'b0, i[1], !i[0]};
            wr(8'h02, v);
            rd(8'h02, v);
            chk("lock", {8'h0, lock_mode_out}, {8'h0, i[1:0]});
            chk("proto", {9'h0, input_device_protocol_out}, {9'h0, i == 2});
            chk("modes", {7'h0, burst_loop_lock_mode_out, demodulator_bypass_out,
                chroma_interpolation_enable_out}, {7'h0, i[0], i[1], !i[0]});
        end
        rd(8'h03, 8'h00);
        wr(8'h02, 8'h00);
        $display("mode test done");
    endtask
    task automatic t_route();
        wr(8'h01, 8'h00);
        pix(10'h123, 10'h2AA);
        chk("out_a", input_proc_out_a_out, 10'h123);
        chk("out_b", input_proc_out_b_out, 10'h2AA);
        @(posedge core_clk_in);
        #1 chk("primary", primary_out, 10'h123);
        chk("secondary", secondary_out, 10'h2AA);
        wr(8'h01, 8'h66);
        pix(10'h123, 10'h2AA);
        chk("out_a", input_proc_out_a_out, 10'h2A8);
        chk("out_b", input_proc_out_b_out, 10'h320);
        @(posedge core_clk_in);
        #1 chk("primary", primary_out, 10'h320);
        chk("secondary", secondary_out, 10'h2A8);
        $display("route test done");
    endtask
    task automatic t_blank();
        wr(8'h01, 8'h08);
        pix(10'h3FF, 10'h000);
        chk("out_a", input_proc_out_a_out, 10'h040);
        chk("out_b", input_proc_out_b_out, 10'h200);
        wr(8'h02, 8'h10);
        pix(10'h3FF, 10'h3FF);
        chk("out_a", input_proc_out_a_out, 10'h010);
        wr(8'h02, 8'h00);
        $display("blank test done");
    endtask
    task automatic t_rate();
        wr(8'h01, 8'h01);
        repeat (2) @(posedge core_clk_in);
        #1 h0 = pcnt;
        repeat (8) @(posedge core_clk_in);
        #1 chk("valid count", pcnt - h0, 10'h004);
        wr(8'h01, 8'h00);
        $display("rate test done");
    endtask
    task automatic t_kill();
        burst_threshold_value_in <= 8'h80;
        src.lines(127, 8'h10);
        src.sync_pulse(1'b1);
        repeat (6) @(posedge core_clk_in);
        wait_kill(1'b0);
        src.lines(128, 8'h10);
        src.sync_pulse(1'b1);
        wait_kill(1'b1);
        pix(10'h040, 10'h2AA);
        @(posedge core_clk_in);
        #1 chk("chroma", chroma_out, 10'h200);
        wr(8'h02, 8'h02);
        pix(10'h040, 10'h2AA);
        @(posedge core_clk_in);
        #1 chk("chroma", chroma_out, 10'h2AA);
        wr(8'h02, 8'h04);
        wait_kill(1'b0);
        wr(8'h02, 8'h00);
        $display("kill test done");
    endtask
    task automatic t_sync();
        h0 = hcnt;
        v0 = vcnt;
        src.sync_pulse(1'b0);
        src.sync_pulse(1'b1);
        repeat (4) @(posedge core_clk_in);
        #1 chk("h pulses", hcnt - h0, 10'h001);
        chk("v pulses", vcnt - v0, 10'h001);
        wr(8'h01, 8'h10);
        h0 = hcnt;
        v0 = vcnt;
        src.send(10'h3FF, 10'h200);
        src.send(10'h000, 10'h200);
        src.send(10'h000, 10'h200);
        src.send(10'h140, 10'h200);
        src.send(10'h3FF, 10'h200);
        src.send(10'h000, 10'h200);
        src.send(10'h000, 10'h200);
        src.send(10'h3C0, 10'h200);
        src.send(10'h200, 10'h200);
        src.sync_pulse(1'b0);
        repeat (4) @(posedge core_clk_in);
        #1 chk("h pulses", hcnt - h0, 10'h002);
        chk("v pulses", vcnt - v0, 10'h001);
        $display("sync test done");
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        rst_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        reg_write_in = 1'b0;
        reg_read_in = 1'b0;
        burst_threshold_value_in = 8'h80;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        t_modes();
        t_route();
        t_blank();
        t_rate();
        t_kill();
        t_sync();
        report_and_stop();
    end
    // Watchdog against a hang anywhere in the sequence.
    initial
    begin
        #2ms;
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== verif/video_ctrl_asserts.sv ====
`default_nettype none
// Watches the register port and the mode outputs of the control block.
module video_ctrl_asserts (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Control port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // Observed outputs.
    input wire logic proc_valid_out,
    input wire logic decoder_valid_out,
    input wire logic [1:0] lock_mode_out,
    input wire logic input_device_protocol_out,
    input wire logic burst_loop_lock_mode_out,
    input wire logic clock_type_select_out,
    input wire logic demodulator_bypass_out,
    input wire logic colour_kill_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // Writes to each of the two control registers.
    sequence blc_wr;
        reg_write_in && reg_addr_in == 8'h02;
    endsequence
    sequence ipc_wr;
        reg_write_in && reg_addr_in == 8'h01;
    endsequence
    lock_write_a: assert property (blc_wr |=> lock_mode_out == $past(reg_wdata_in[5:4]))
        else $error("lock mode differs from written value");
    loop_write_a: assert property (blc_wr |=> burst_loop_lock_mode_out == $past(reg_wdata_in[3]))
        else $error("loop mode differs from written value");
    bypass_write_a: assert property (blc_wr |=> demodulator_bypass_out == $past(reg_wdata_in[1]))
        else $error("bypass differs from written value");
    clock_write_a: assert property (ipc_wr |=> clock_type_select_out == $past(reg_wdata_in[0]))
        else $error("clock type differs from written value");
    proto_gate_a: assert property (input_device_protocol_out |-> $past(lock_mode_out) == 2'h2)
        else $error("protocol bit outside processor mode");
    kill_off_a: assert property (blc_wr ##0 reg_wdata_in[2] |-> ##2 !colour_kill_out)
        else $error("colour killed while disabled");
    unmapped_read_a: assert property (reg_read_in && !(reg_addr_in inside {8'h01, 8'h02})
        |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    pipe_valid_a: assert property (proc_valid_out |=> decoder_valid_out)
        else $error("decoder valid missing after input valid");
    rate_half_a: assert property (clock_type_select_out [*3] |-> !(proc_valid_out && $past(proc_valid_out)))
        else $error("back to back samples in line locked mode");
endmodule
bind video_input_and_burst_loop_control video_ctrl_asserts u_chk (.*);
`default_nettype wire

// ==== verif/video_src_model.sv ====
`default_nettype none
// Stands in for the video source feeding the two sample buses, syncs and burst meter.
module video_src_model (
    // Clock.
    input wire logic core_clk_in,
    // Source outputs.
    output logic [9:0] bus_a_out,
    output logic [9:0] bus_b_out,
    output logic hsync_out,
    output logic vsync_out,
    output logic [7:0] burst_level_out,
    output logic burst_line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle stream is blank luma on A and blank chroma on B, syncs low.
    initial
    begin
        bus_a_out = 10'h040;
        bus_b_out = 10'h200;
        hsync_out = 1'b0;
        vsync_out = 1'b0;
        burst_level_out = 8'hFF;
        burst_line_out = 1'b0;
    end
    // One sample pair; a goes out on bus A and b on bus B.
    task automatic send(input logic [9:0] a, input logic [9:0] b);
        @(posedge core_clk_in);
        bus_a_out <= a;
        bus_b_out <= b;
    endtask
    // A sync rising edge, held two clocks so the edge detector sees it.
    task automatic sync_pulse(input logic v);
        @(posedge core_clk_in);
        vsync_out <= v;
        hsync_out <= !v;
        repeat (2) @(posedge core_clk_in);
        vsync_out <= 1'b0;
        hsync_out <= 1'b0;
    endtask
    // A run of measured lines, each a one-clock pulse with its burst level.
    task automatic lines(input int n, input logic [7:0] lvl);
        repeat (n)
        begin
            @(posedge core_clk_in);
            burst_level_out <= lvl;
            burst_line_out <= 1'b1;
            @(posedge core_clk_in);
            burst_line_out <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== verilog/colour_killer.sv ====
`default_nettype none
`include "video_ctrl_consts.svh"
module colour_killer
    import video_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Burst measurements and kill decision.
    video_ctrl_if.killer ctl
);
    killer_state_t s_r; // Registered state.
    killer_state_t s_nxt; // Next state.

    // Count low-burst lines through a field and judge at the field boundary.
    always_comb
    begin
        s_nxt = s_r;
        if (ctl.burst_line && (ctl.burst_level < ctl.threshold)
            && (s_r.count != `KILL_COUNT_MAX))
        begin
            // The count saturates so a long field cannot wrap below the limit.
            s_nxt.count = s_r.count + 8'h01;
        end
        if (ctl.field_start)
        begin
            // The verdict on the field just ended governs the whole next field.
            s_nxt.field_kill = (s_r.count > `KILL_LINE_LIMIT);
            s_nxt.count = 8'h00;
        end
        // The disable bit overrides any verdict at once.
        s_nxt.kill = s_nxt.field_kill & ~ctl.kill_disable;
    end

    // State register.
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ctl.kill = s_r.kill;
endmodule
`default_nettype wire

// ==== verilog/input_swap_mux.sv ====
`default_nettype none
module input_swap_mux (
    // Control from the register bank.
    video_ctrl_if.mux ctl,
    // Raw input buses.
    input wire logic [9:0] video_bus_a_in,
    input wire logic [9:0] video_bus_b_in,
    // Routed internal paths.
    output logic [9:0] internal_path_a_out,
    output logic [9:0] internal_path_b_out
);
    // Routing, truncation and sign inversion are pure wiring, so no state.
    always_comb
    begin
        internal_path_a_out = ctl.swap_sel ? video_bus_b_in : video_bus_a_in;
        internal_path_b_out = ctl.swap_sel ? video_bus_a_in : video_bus_b_in;
        if (ctl.eight_bit)
        begin
            // Both buses lose their two bottom bits before anything looks at them.
            internal_path_a_out[1:0] = 2'h0;
            internal_path_b_out[1:0] = 2'h0;
        end
        if (ctl.invert_msb)
        begin
            // Path B always carries chroma; path A only on D1 chroma slots.
            internal_path_b_out[9] = ~internal_path_b_out[9];
            if (ctl.chroma_on_a)
            begin
                internal_path_a_out[9] = ~internal_path_a_out[9];
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/video_ctrl_consts.svh ====
`ifndef VIDEO_CTRL_CONSTS_SVH
`define VIDEO_CTRL_CONSTS_SVH
// Register offsets on the control port.
`define IPC_OFFSET 8'h01
`define BLC_OFFSET 8'h02
// Reset values; the top bit of each register is reserved and reads zero.
`define IPC_RESET 8'h00
`define BLC_RESET 8'h00
`define CTRL_WRITE_MASK 8'h7F
// Field positions of the input processor control register.
`define IPC_SWAP 6
`define IPC_EIGHT 5
`define IPC_TIMING_REF_DETECT_ENABLE 4
`define IPC_TIMING_REF_BLANK_ENABLE 3
`define IPC_CINV 2
`define IPC_PRIM 1
`define IPC_CLK 0
// Field positions of the burst loop control register.
`define BLC_PROTO 6
`define BLC_LOCK_HI 5
`define BLC_LOCK_LO 4
`define BLC_BLM 3
`define BLC_COLOUR_KILL_DISABLE 2
`define BLC_BYP 1
`define BLC_CHROMA_INTERPOLATION_ENABLE 0
// Video levels on the 10-bit scale.
`define LUMA_BLANK 10'h040
`define CHROMA_BLANK 10'h200
`define SYNC_TIP 10'h010
// Upper eight bits of the reserved words that open a timing reference.
`define TRS_ONES 8'hFF
`define TRS_ZEROS 8'h00
// Flag bits of the timing reference status word.
`define XYZ_V_BIT 7
`define XYZ_H_BIT 6
// Lines of low burst per field above which colour is killed.
`define KILL_LINE_LIMIT 8'h7F
`define KILL_COUNT_MAX 8'hFF
`endif

// ==== verilog/video_ctrl_if.sv ====
`default_nettype none
// Control bits passed from the register bank and the burst pins to the input and killer logic, with the kill result passed back.
interface video_ctrl_if;
    logic swap_sel;
    logic eight_bit;
    logic invert_msb;
    logic chroma_on_a;
    logic field_start;
    logic burst_line;
    logic kill_disable;
    logic [7:0] burst_level;
    logic [7:0] threshold;
    logic kill;
    modport ctrl (output swap_sel, eight_bit, invert_msb, chroma_on_a, field_start,
                  burst_line, kill_disable, burst_level, threshold, input kill);
    modport mux (input swap_sel, eight_bit, invert_msb, chroma_on_a);
    modport killer (input field_start, burst_line, kill_disable, burst_level, threshold,
                    output kill);
endinterface
`default_nettype wire

// ==== verilog/video_ctrl_pkg.sv ====
`default_nettype none
package video_ctrl_pkg;
    // Global lock modes, coded as the two-bit register field.
    typedef enum logic [1:0] {
        LOCK_LINE = 2'h0,
        LOCK_SUBCARRIER = 2'h1,
        LOCK_PROCESSOR = 2'h2,
        LOCK_D1 = 2'h3
    } lock_mode_t;
    // Progress through the preamble of a timing reference.
    typedef enum logic [1:0] {TRS_IDLE, TRS_ONE, TRS_TWO, TRS_THREE} trs_state_t;
    // Colour killer state.
    typedef struct packed {
        logic [7:0] count;
        logic field_kill;
        logic kill;
    } killer_state_t;
    // Register bank and datapath state.
    typedef struct packed {
        logic [7:0] ipc;
        logic [7:0] blc;
        logic [7:0] rdata;
        logic alt_protocol;
        logic pix_toggle;
        trs_state_t trs;
        logic chroma_phase;
        logic v_prev;
        logic hsync_prev;
        logic vsync_prev;
        logic h_reset;
        logic v_reset;
        logic valid;
        logic [9:0] out_a;
        logic [9:0] out_b;
        logic out_valid;
        logic [9:0] primary;
        logic [9:0] secondary;
        logic [9:0] chroma_prev;
        logic [9:0] chroma;
        logic interp_phase;
    } top_state_t;
endpackage
`default_nettype wire

// ==== verilog/video_input_and_burst_loop_control.sv ====
`default_nettype none
`include "video_ctrl_consts.svh"
module video_input_and_burst_loop_control
    import video_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Control port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Video input.
    input wire logic [9:0] video_bus_a_in,
    input wire logic [9:0] video_bus_b_in,
    input wire logic hsync_in,
    input wire logic vsync_in,
    // Burst measurement.
    input wire logic [7:0] burst_level_in,
    input wire logic burst_line_in,
    input wire logic [7:0] burst_threshold_value_in,
    // Input processor outputs.
    output logic [9:0] input_proc_out_a_out,
    output logic [9:0] input_proc_out_b_out,
    output logic proc_valid_out,
    // Decoder inputs.
    output logic [9:0] primary_out,
    output logic [9:0] secondary_out,
    output logic [9:0] chroma_out,
    output logic decoder_valid_out,
    // Timing resets.
    output logic h_reset_out,
    output logic v_reset_out,
    // Mode outputs.
    output logic [1:0] lock_mode_out,
    output logic input_device_protocol_out,
    output logic burst_loop_lock_mode_out,
    output logic clock_type_select_out,
    output logic demodulator_bypass_out,
    output logic chroma_interpolation_enable_out,
    output logic colour_kill_out
);
    top_state_t s_r; // Registered state.
    top_state_t s_nxt; // Next state.

    video_ctrl_if ctl (); // Control bundle to the submodules.

    logic [9:0] internal_path_a; // Routed path A.
    logic [9:0] internal_path_b; // Routed path B.
    logic pix_en; // One sample per enable.
    logic d1_mode; // D1 lock mode selected.
    logic d2_mode; // Subcarrier-locked composite selected.
    logic is_ones; // Path A holds an all-ones word.
    logic is_zeros; // Path A holds an all-zeros word.
    logic is_ref_word; // Path A holds a reference or ancillary word.
    logic trs_found; // Status word of a reference on path A.
    logic h_flag; // Horizontal flag of the status word.
    logic v_flag; // Vertical flag of the status word.
    logic [9:0] chroma_src; // Chroma sample feeding the chroma output.
    logic [10:0] chroma_sum; // Sum of two neighbouring chroma samples.

    // Settings move to the submodules straight from the registers; burst line, level and threshold come straight from the pins.
    assign ctl.swap_sel = s_r.ipc[`IPC_SWAP];
    assign ctl.eight_bit = s_r.ipc[`IPC_EIGHT];
    assign ctl.invert_msb = s_r.ipc[`IPC_CINV];
    assign ctl.chroma_on_a = d1_mode & s_r.chroma_phase;
    assign ctl.field_start = s_r.v_reset;
    assign ctl.burst_line = burst_line_in;
    assign ctl.burst_level = burst_level_in;
    assign ctl.threshold = burst_threshold_value_in;
    assign ctl.kill_disable = s_r.blc[`BLC_COLOUR_KILL_DISABLE];

    // Routing, truncation and sign inversion.
    input_swap_mux u_mux (
        .ctl (ctl.mux),
        .video_bus_a_in (video_bus_a_in),
        .video_bus_b_in (video_bus_b_in),
        .internal_path_a_out (internal_path_a),
        .internal_path_b_out (internal_path_b)
    );

    // Low-burst line counting and field kill.
    colour_killer u_killer (
        .core_clk_in (core_clk_in),
        .rst_in (rst_in),
        .ctl (ctl.killer)
    );

    // Word classification on path A, shared by detection and blanking.
    always_comb
    begin
        d1_mode = (s_r.blc[`BLC_LOCK_HI:`BLC_LOCK_LO] == LOCK_D1);
        d2_mode = (s_r.blc[`BLC_LOCK_HI:`BLC_LOCK_LO] == LOCK_SUBCARRIER);
        // Only the top eight bits are compared so eight-bit sources match too.
        is_ones = (internal_path_a[9:2] == `TRS_ONES);
        is_zeros = (internal_path_a[9:2] == `TRS_ZEROS);
        trs_found = (s_r.trs == TRS_THREE);
        is_ref_word = is_ones | is_zeros | trs_found;
        h_flag = internal_path_a[`XYZ_H_BIT];
        v_flag = internal_path_a[`XYZ_V_BIT];
        // A line-locked clock runs at twice the sample rate, so take every other edge.
        pix_en = ~s_r.ipc[`IPC_CLK] | s_r.pix_toggle;
        chroma_src = s_r.ipc[`IPC_PRIM] ? s_r.out_a : s_r.out_b;
        chroma_sum = {1'b0, s_r.chroma_prev} + {1'b0, chroma_src};
    end

    // Next-state logic for the registers and the datapath.
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.h_reset = 1'b0;
        s_nxt.v_reset = 1'b0;

        // Writes land at this edge and steer the datapath from the next one.
        if (reg_write_in)
        begin
            if (reg_addr_in == `IPC_OFFSET)
            begin
                // The reserved top bit is not stored, so it always reads zero.
                s_nxt.ipc = reg_wdata_in & `CTRL_WRITE_MASK;
            end
            else if (reg_addr_in == `BLC_OFFSET)
            begin
                s_nxt.blc = reg_wdata_in & `CTRL_WRITE_MASK;
            end
        end

        // Reads answer one clock later; unmapped offsets read as zero.
        if (reg_read_in)
        begin
            if (reg_addr_in == `IPC_OFFSET)
            begin
                s_nxt.rdata = s_r.ipc;
            end
            else if (reg_addr_in == `BLC_OFFSET)
            begin
                s_nxt.rdata = s_r.blc;
            end
            else
            begin
                s_nxt.rdata = 8'h00;
            end
        end

        // The alternative protocol is offered only in processor lock mode.
        s_nxt.alt_protocol = s_r.blc[`BLC_PROTO]
                             & (s_r.blc[`BLC_LOCK_HI:`BLC_LOCK_LO] == LOCK_PROCESSOR);

        // Sample enable divider for line-locked clocks.
        s_nxt.pix_toggle = s_r.ipc[`IPC_CLK] ? ~s_r.pix_toggle : 1'b1;
        s_nxt.valid = pix_en;

        // Sync pin history is sampled every clock whichever source is chosen.
        s_nxt.hsync_prev = hsync_in;
        s_nxt.vsync_prev = vsync_in;
        if (!s_r.ipc[`IPC_TIMING_REF_DETECT_ENABLE])
        begin
            // Pin timing only; embedded references are ignored.
            s_nxt.h_reset = hsync_in & ~s_r.hsync_prev;
            s_nxt.v_reset = vsync_in & ~s_r.vsync_prev;
        end

        if (pix_en)
        begin
            // Walk the all-ones, zeros, zeros preamble on path A.
            unique case (s_r.trs)
                TRS_IDLE:
                begin
                    s_nxt.trs = is_ones ? TRS_ONE : TRS_IDLE;
                end
                TRS_ONE:
                begin
                    s_nxt.trs = is_zeros ? TRS_TWO : (is_ones ? TRS_ONE : TRS_IDLE);
                end
                TRS_TWO:
                begin
                    s_nxt.trs = is_zeros ? TRS_THREE : (is_ones ? TRS_ONE : TRS_IDLE);
                end
                TRS_THREE:
                begin
                    // The status word ends the preamble whatever it holds.
                    s_nxt.trs = TRS_IDLE;
                end
            endcase

            // Status word: restart the D1 slot count and, if chosen, the timing.
            if (trs_found)
            begin
                s_nxt.chroma_phase = 1'b1;
                if (s_r.ipc[`IPC_TIMING_REF_DETECT_ENABLE])
                begin
                    // Line end sets the horizontal reset, rising vertical the field reset.
                    s_nxt.h_reset = h_flag;
                    s_nxt.v_reset = h_flag & v_flag & ~s_r.v_prev;
                    s_nxt.v_prev = h_flag ? v_flag : s_r.v_prev;
                end
            end
            else
            begin
                // D1 alternates colour difference and luma slots on path A.
                s_nxt.chroma_phase = ~s_r.chroma_phase;
            end

            // Input processor outputs, blanked over reference words when asked.
            s_nxt.out_a = internal_path_a;
            s_nxt.out_b = internal_path_b;
            if (s_r.ipc[`IPC_TIMING_REF_BLANK_ENABLE] && is_ref_word)
            begin
                if (d2_mode)
                begin
                    // Composite at four times subcarrier has no separate blank level.
                    s_nxt.out_a = `SYNC_TIP;
                end
                else if (d1_mode && s_r.chroma_phase)
                begin
                    s_nxt.out_a = `CHROMA_BLANK;
                end
                else
                begin
                    s_nxt.out_a = `LUMA_BLANK;
                end
                s_nxt.out_b = `CHROMA_BLANK;
            end
        end

        // Decoder stage: choose primary and secondary, then shape chroma.
        s_nxt.out_valid = s_r.valid;
        if (s_r.valid)
        begin
            if (s_r.ipc[`IPC_PRIM])
            begin
                s_nxt.primary = s_r.out_b;
                s_nxt.secondary = s_r.out_a;
            end
            else
            begin
                s_nxt.primary = s_r.out_a;
                s_nxt.secondary = s_r.out_b;
            end
            s_nxt.chroma_prev = chroma_src;
            s_nxt.interp_phase = ~s_r.interp_phase;
            if (s_r.blc[`BLC_BYP])
            begin
                // Bypass wins over everything so the sample reaches the output untouched.
                s_nxt.chroma = chroma_src;
            end
            else if (ctl.kill)
            begin
                s_nxt.chroma = `CHROMA_BLANK;
            end
            else if (s_r.blc[`BLC_CHROMA_INTERPOLATION_ENABLE] && s_r.interp_phase)
            begin
                // Missing samples take the mean of their neighbours; cheap, not a full filter.
                s_nxt.chroma = chroma_sum[10:1];
            end
            else
            begin
                s_nxt.chroma = chroma_src;
            end
        end
    end

    // State register; the bank has no documented reset value, so it clears.
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s_r <= '0;
            s_r.ipc <= `IPC_RESET;
            s_r.blc <= `BLC_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Every output is a register bit.
    assign reg_rdata_out = s_r.rdata;
    assign input_proc_out_a_out = s_r.out_a;
    assign input_proc_out_b_out = s_r.out_b;
    assign proc_valid_out = s_r.valid;
    assign primary_out = s_r.primary;
    assign secondary_out = s_r.secondary;
    assign chroma_out = s_r.chroma;
    assign decoder_valid_out = s_r.out_valid;
    assign h_reset_out = s_r.h_reset;
    assign v_reset_out = s_r.v_reset;
    assign lock_mode_out = s_r.blc[`BLC_LOCK_HI:`BLC_LOCK_LO];
    assign input_device_protocol_out = s_r.alt_protocol;
    assign burst_loop_lock_mode_out = s_r.blc[`BLC_BLM];
    assign clock_type_select_out = s_r.ipc[`IPC_CLK];
    assign demodulator_bypass_out = s_r.blc[`BLC_BYP];
    assign chroma_interpolation_enable_out = s_r.blc[`BLC_CHROMA_INTERPOLATION_ENABLE];
    assign colour_kill_out = ctl.kill;
endmodule
`default_nettype wire
